// ### core/vvl_pkg.sv
// Command codes, reset values and carriers for the voltage limit bank.
// Assumes a 200 MHz core clock and 2^-12 V output-voltage codes.
package vvl_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_FORMAT    = 8'h20;
  localparam logic [7:0] CMD_SETPOINT  = 8'h21;
  localparam logic [7:0] CMD_CEIL      = 8'h24;
  localparam logic [7:0] CMD_MHIGH     = 8'h25;
  localparam logic [7:0] CMD_MLOW      = 8'h26;
  localparam logic [7:0] CMD_VIN_START = 8'h35;
  localparam logic [7:0] CMD_VIN_STOP  = 8'h36;
  localparam logic [7:0] CMD_OV_FAULT  = 8'h40;
  localparam logic [7:0] CMD_OV_WARN   = 8'h42;
  localparam logic [7:0] CMD_UV_WARN   = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT  = 8'h44;
  localparam logic [7:0] CMD_VIN_OV    = 8'h55;
  localparam logic [7:0] CMD_VIN_UVW   = 8'h58;
  localparam logic [7:0] CMD_FIX_CEIL  = 8'hA5;
  localparam logic [7:0] CMD_LOAD_LINE = 8'hD3;
  localparam logic [7:0] PAGE_ALL      = 8'hFF;

  // ==========================================================
  // Reset and fixed values
  localparam logic [7:0]  FORMAT_VAL    = 8'h14;
  localparam logic [15:0] RST_SETPOINT  = 16'h1000;
  localparam logic [15:0] RST_CEIL      = 16'h5800;
  localparam logic [15:0] RST_MHIGH     = 16'h10CD;
  localparam logic [15:0] RST_MLOW      = 16'h0F33;
  localparam logic [15:0] RST_VIN_START = 16'hCB40;
  localparam logic [15:0] RST_VIN_STOP  = 16'hCB00;
  localparam logic [15:0] RST_OV_FAULT  = 16'h119A;
  localparam logic [15:0] RST_OV_WARN   = 16'h1133;
  localparam logic [15:0] RST_UV_WARN   = 16'h0ECD;
  localparam logic [15:0] RST_UV_FAULT  = 16'h0E66;
  localparam logic [15:0] RST_VIN_OV    = 16'hD3E0;
  localparam logic [15:0] RST_VIN_UVW   = 16'hCB26;
  localparam logic [15:0] RST_LOAD_LINE = 16'h8000;
  localparam logic [15:0] FIX_CEIL_VAL  = 16'h599A;
  // Range ceilings: 5.5 V and 2.75 V in 2^-12 V codes
  localparam logic [15:0] RANGE0_LIM    = 16'h5800;
  localparam logic [15:0] RANGE1_LIM    = 16'h2C00;

  // ==========================================================
  // Margin select and status bits
  localparam logic [1:0] MARG_NOM  = 2'h0;
  localparam logic [1:0] MARG_LOW  = 2'h1;
  localparam logic [1:0] MARG_HIGH = 2'h2;
  localparam logic [7:0] CS_OV_MASK = 8'h60;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned OV_SETTLE_MS   = 10;
  localparam int unsigned OV_SETTLE_CYC  = OV_SETTLE_MS * CLK_KHZ;
  // 0.25 V/ms is 1024 codes per ms
  localparam int unsigned SLEW_LSB_PER_MS = 1024;
  localparam int unsigned SLEW_CYC       = CLK_KHZ / SLEW_LSB_PER_MS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        wr;
    logic [7:0]  page;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } vvl_req_s;

  typedef struct packed {
    logic        cml;
    logic [15:0] rdata;
  } vvl_rsp_s;

  typedef struct packed {
    logic input_sum;
    logic input_uvw;
    logic vin_ov;
    logic cml;
  } vvl_stat_s;

endpackage

// ### core/vvl_link_port.sv
// Link-side command port: captures one request and waits for the answer.
// Assumes the core returns the answer no later than it toggles its acknowledge.
`timescale 1ns/1ps
module vvl_link_port (
  // Link clock and reset
  input  wire logic             link_clk_i,
  input  wire logic             rst_n_i,
  // Host side
  input  wire logic             req_valid_i,
  input  wire vvl_pkg::vvl_req_s req_i,
  output logic                  busy_o,
  output logic                  done_o,
  output vvl_pkg::vvl_rsp_s     rsp_o,
  // Core side
  output vvl_pkg::vvl_req_s     req_o,
  output logic                  req_tgl_o,
  input  wire vvl_pkg::vvl_rsp_s rsp_i,
  input  wire logic             ack_tgl_i
);

  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_WAIT = 2'b10
  } vvl_lk_e;

  typedef struct packed {
    vvl_lk_e           st;
    vvl_pkg::vvl_req_s req;
    logic              tgl;
    logic              ack_s1;
    logic              ack_s2;
    vvl_pkg::vvl_rsp_s rsp;
    logic              done;
  } vvl_lk_s;

  vvl_lk_s q;
  vvl_lk_s n;

  // ==========================================================
  // Request capture and answer return
  always_comb begin
    n = q;
    n.ack_s1 = ack_tgl_i;
    n.ack_s2 = q.ack_s1;
    n.done = 1'b0;
    unique case (q.st)
      LK_IDLE: begin
        // Request word held stable until the core answers
        if (req_valid_i) begin
          n.req = req_i;
          n.tgl = ~q.tgl;
          n.st = LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (q.ack_s2 == q.tgl) begin
          n.rsp = rsp_i;
          n.done = 1'b1;
          n.st = LK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: LK_IDLE, default: '0};
    end else begin
      q <= n;
    end
  end

  assign busy_o    = (q.st == LK_WAIT);
  assign done_o    = q.done;
  assign rsp_o     = q.rsp;
  assign req_o     = q.req;
  assign req_tgl_o = q.tgl;

endmodule

// ### core/vvl_limit_bank.sv
// Input and output voltage limit command bank, reached by command code.
// Assumes measurements, enables and margin selects come from core-clock logic;
// the host command port runs on its own link clock.
`timescale 1ns/1ps

module vvl_limit_bank #(
  parameter int          NCH           = 2,
  parameter int unsigned OV_SETTLE_CYC = vvl_pkg::OV_SETTLE_CYC,
  parameter int unsigned SLEW_CYC      = vvl_pkg::SLEW_CYC
) (
  // Clocks and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       link_clk_i,
  input  wire logic                       rst_n_i,
  // Host command port, link clock
  input  wire logic                       req_valid_i,
  input  wire vvl_pkg::vvl_req_s          req_i,
  output logic                            busy_o,
  output logic                            done_o,
  output vvl_pkg::vvl_rsp_s               rsp_o,
  // Measurements and channel state
  input  wire logic [15:0]                vin_adc_i,
  input  wire logic [NCH-1:0][15:0]       sense_i,
  input  wire logic [NCH-1:0]             enable_i,
  input  wire logic [NCH-1:0]             ramp_busy_i,
  input  wire logic [NCH-1:0][1:0]        margin_i,
  input  wire logic [NCH-1:0]             range_i,
  input  wire logic [NCH-1:0]             servo_req_i,
  // Status control
  input  wire logic                       status_clr_i,
  input  wire logic                       mask_uvw_i,
  input  wire logic                       mask_vmax_i,
  // Outputs
  output logic [NCH-1:0][15:0]            vout_ref_o,
  output logic                            conv_en_o,
  output logic [NCH-1:0]                  ov_fault_o,
  output logic [NCH-1:0]                  vout_sum_o,
  output logic [NCH-1:0]                  vout_cap_warn_o,
  output logic [NCH-1:0]                  servo_en_o,
  output logic [NCH-1:0]                  load_line_on_o,
  output vvl_pkg::vvl_stat_s              status_o,
  output logic [7:0]                      common_vendor_status_o,
  output logic                            alert_n_o
);

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // ==========================================================
  // Per-channel and whole state
  typedef struct packed {
    logic [15:0] setpoint;
    logic [15:0] ceil;
    logic [15:0] mhigh;
    logic [15:0] mlow;
    logic [15:0] ov_lim;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_lim;
    logic [15:0] load_line;
    logic [15:0] applied;
    logic [15:0] ref_v;
  } vvl_ch_s;

  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic                  ack;
    vvl_pkg::vvl_rsp_s     rsp;
    logic [15:0]           vin_start;
    logic [15:0]           vin_stop;
    logic [15:0]           vin_ov;
    logic [15:0]           vin_uvw;
    vvl_ch_s [NCH-1:0]     ch;
    logic                  conv_on;
    logic                  uvw_arm;
    vvl_pkg::vvl_stat_s    st;
    logic [NCH-1:0]        st_vout;
    logic [NCH-1:0]        st_vmax;
    logic [NCH-1:0]        ovf;
    logic [31:0]           settle;
    logic [31:0]           slew_cnt;
  } vvl_st_s;

  vvl_st_s q;
  vvl_st_s n;

  // ==========================================================
  // Helpers
  // Linear 5s/11s to unsigned fixed point, 8 fraction bits
  function automatic logic [39:0] l11_val(input logic [15:0] w);
    logic [39:0] v;
    logic [4:0]  e;
    v = {29'h0000_0000, (w[10] ? 11'h000 : w[10:0])} << 8;
    e = w[15:11];
    if (e[4]) begin
      l11_val = v >> (~e + 5'h01);
    end else begin
      l11_val = v << e;
    end
  endfunction

  function automatic logic is_paged(input logic [7:0] c);
    is_paged = !(c == vvl_pkg::CMD_VIN_START || c == vvl_pkg::CMD_VIN_STOP ||
                 c == vvl_pkg::CMD_VIN_OV || c == vvl_pkg::CMD_VIN_UVW);
  endfunction

  function automatic logic is_known(input logic [7:0] c);
    case (c)
      vvl_pkg::CMD_FORMAT, vvl_pkg::CMD_SETPOINT, vvl_pkg::CMD_CEIL,
      vvl_pkg::CMD_MHIGH, vvl_pkg::CMD_MLOW, vvl_pkg::CMD_VIN_START,
      vvl_pkg::CMD_VIN_STOP, vvl_pkg::CMD_OV_FAULT, vvl_pkg::CMD_OV_WARN,
      vvl_pkg::CMD_UV_WARN, vvl_pkg::CMD_UV_FAULT, vvl_pkg::CMD_VIN_OV,
      vvl_pkg::CMD_VIN_UVW, vvl_pkg::CMD_FIX_CEIL,
      vvl_pkg::CMD_LOAD_LINE: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Link port and crossing
  vvl_pkg::vvl_req_s req;
  logic              req_tgl;

  vvl_link_port u_link (
    .link_clk_i  (link_clk_i),
    .rst_n_i     (rst_n_i),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .busy_o      (busy_o),
    .done_o      (done_o),
    .rsp_o       (rsp_o),
    .req_o       (req),
    .req_tgl_o   (req_tgl),
    .rsp_i       (q.rsp),
    .ack_tgl_i   (q.ack)
  );

  // ==========================================================
  // Decode and targets
  logic                  evt;
  logic                  all_pg;
  logic                  pg_ok;
  logic [CW-1:0]         rd_ch;
  logic [15:0]           wcap;
  logic                  wover;
  logic [39:0]           vin_v;
  logic [NCH-1:0][15:0]  tgt;

  assign evt    = q.s2 ^ q.s3;
  assign all_pg = (req.page == vvl_pkg::PAGE_ALL);
  assign pg_ok  = all_pg || (req.page < 8'(NCH));
  assign rd_ch  = all_pg ? '0 : req.page[CW-1:0];
  assign wover  = (req.wdata > vvl_pkg::FIX_CEIL_VAL);
  assign wcap   = wover ? vvl_pkg::FIX_CEIL_VAL : req.wdata;
  assign vin_v  = l11_val(vin_adc_i);

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign tgt[g] = (margin_i[g] == vvl_pkg::MARG_HIGH) ? q.ch[g].mhigh :
                    (margin_i[g] == vvl_pkg::MARG_LOW)  ? q.ch[g].mlow  :
                                                          q.ch[g].setpoint;
    assign vout_ref_o[g]     = q.ch[g].ref_v;
    assign load_line_on_o[g] = (q.ch[g].load_line[10:0] != 11'h000);
    assign servo_en_o[g]     = servo_req_i[g] & ~load_line_on_o[g];
  end

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.s1 = req_tgl;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Clear first so a same-cycle event still lands
    if (status_clr_i) begin
      n.st = '0;
      n.st_vout = '0;
      n.st_vmax = '0;
      n.ovf = '0;
    end
    if (q.settle != 32'h0000_0000) begin
      n.settle = q.settle - 32'h0000_0001;
    end
    n.slew_cnt = (q.slew_cnt >= 32'(SLEW_CYC - 1)) ? 32'h0000_0000 :
                 q.slew_cnt + 32'h0000_0001;

    // Host command
    if (evt) begin
      n.ack = q.s2;
      n.rsp = '0;
      if (!is_known(req.cmd) || (is_paged(req.cmd) && !pg_ok)) begin
        n.rsp.cml = 1'b1;
      end else if (req.wr) begin
        case (req.cmd)
          vvl_pkg::CMD_FORMAT,
          vvl_pkg::CMD_FIX_CEIL: n.rsp.cml = 1'b1;
          vvl_pkg::CMD_VIN_START: n.vin_start = req.wdata;
          vvl_pkg::CMD_VIN_STOP:  n.vin_stop = req.wdata;
          vvl_pkg::CMD_VIN_OV:   n.vin_ov = req.wdata;
          vvl_pkg::CMD_VIN_UVW:  n.vin_uvw = req.wdata;
          default: begin
            if (wover && req.cmd != vvl_pkg::CMD_LOAD_LINE) begin
              n.rsp.cml = 1'b1;
            end
          end
        endcase
        for (int c = 0; c < NCH; c++) begin
          if (all_pg || req.page == 8'(c)) begin
            case (req.cmd)
              vvl_pkg::CMD_SETPOINT:  n.ch[c].setpoint = wcap;
              vvl_pkg::CMD_CEIL:      n.ch[c].ceil = wcap;
              vvl_pkg::CMD_MHIGH:     n.ch[c].mhigh = wcap;
              vvl_pkg::CMD_MLOW:      n.ch[c].mlow = wcap;
              vvl_pkg::CMD_OV_FAULT: begin
                n.ch[c].ov_lim = wcap;
                if (enable_i[c]) begin
                  n.settle = OV_SETTLE_CYC;
                end
              end
              vvl_pkg::CMD_OV_WARN:   n.ch[c].ov_warn = wcap;
              vvl_pkg::CMD_UV_WARN:   n.ch[c].uv_warn = wcap;
              vvl_pkg::CMD_UV_FAULT:  n.ch[c].uv_lim = wcap;
              vvl_pkg::CMD_LOAD_LINE: n.ch[c].load_line = req.wdata;
              default: ;
            endcase
          end
        end
      end else begin
        case (req.cmd)
          vvl_pkg::CMD_FORMAT:    n.rsp.rdata = {8'h00, vvl_pkg::FORMAT_VAL};
          vvl_pkg::CMD_SETPOINT:  n.rsp.rdata = q.ch[rd_ch].setpoint;
          vvl_pkg::CMD_CEIL:      n.rsp.rdata = q.ch[rd_ch].ceil;
          vvl_pkg::CMD_MHIGH:     n.rsp.rdata = q.ch[rd_ch].mhigh;
          vvl_pkg::CMD_MLOW:      n.rsp.rdata = q.ch[rd_ch].mlow;
          vvl_pkg::CMD_VIN_START: n.rsp.rdata = q.vin_start;
          vvl_pkg::CMD_VIN_STOP:  n.rsp.rdata = q.vin_stop;
          vvl_pkg::CMD_OV_FAULT:  n.rsp.rdata = q.ch[rd_ch].ov_lim;
          vvl_pkg::CMD_OV_WARN:   n.rsp.rdata = q.ch[rd_ch].ov_warn;
          vvl_pkg::CMD_UV_WARN:   n.rsp.rdata = q.ch[rd_ch].uv_warn;
          vvl_pkg::CMD_UV_FAULT:  n.rsp.rdata = q.ch[rd_ch].uv_lim;
          vvl_pkg::CMD_VIN_OV:    n.rsp.rdata = q.vin_ov;
          vvl_pkg::CMD_VIN_UVW:   n.rsp.rdata = q.vin_uvw;
          vvl_pkg::CMD_FIX_CEIL:  n.rsp.rdata = vvl_pkg::FIX_CEIL_VAL;
          vvl_pkg::CMD_LOAD_LINE: n.rsp.rdata = q.ch[rd_ch].load_line;
          default: ;
        endcase
      end
      if (n.rsp.cml) begin
        n.st.cml = 1'b1;
      end
    end

    // Input supervision
    // Conversion may start
    if (vin_v >= l11_val(q.vin_start)) begin
      n.conv_on = 1'b1;
    end else if (vin_v < l11_val(q.vin_stop)) begin
      n.conv_on = 1'b0;
    end
    if (vin_v > l11_val(q.vin_ov)) begin
      n.st.vin_ov = 1'b1;
    end
    // Arm only after start and enable
    if (enable_i == '0) begin
      n.uvw_arm = 1'b0;
    end else if (vin_v > l11_val(q.vin_start)) begin
      n.uvw_arm = 1'b1;
    end
    if (q.uvw_arm && vin_v < l11_val(q.vin_uvw)) begin
      n.st.input_sum = 1'b1;
      n.st.input_uvw = 1'b1;
    end

    // Output supervision
    for (int c = 0; c < NCH; c++) begin
      if (tgt[c] > q.ch[c].ceil) begin
        n.st_vout[c] = 1'b1;
        n.st_vmax[c] = 1'b1;
        case (margin_i[c])
          vvl_pkg::MARG_HIGH: n.ch[c].mhigh = q.ch[c].ceil;
          vvl_pkg::MARG_LOW:  n.ch[c].mlow = q.ch[c].ceil;
          default:            n.ch[c].setpoint = q.ch[c].ceil;
        endcase
      end
      if (range_i[c] ? (q.ch[c].ceil > vvl_pkg::RANGE1_LIM) :
                       (q.ch[c].ceil > vvl_pkg::RANGE0_LIM)) begin
        n.st_vout[c] = 1'b1;
        n.st_vmax[c] = 1'b1;
      end
      // Hold new target until ramp ends
      if (!ramp_busy_i[c]) begin
        n.ch[c].applied = (tgt[c] > q.ch[c].ceil) ? q.ch[c].ceil : tgt[c];
      end
      if (q.slew_cnt == 32'h0000_0000) begin
        if (q.ch[c].ref_v < q.ch[c].applied) begin
          n.ch[c].ref_v = q.ch[c].ref_v + 16'h0001;
        end else if (q.ch[c].ref_v > q.ch[c].applied) begin
          n.ch[c].ref_v = q.ch[c].ref_v - 16'h0001;
        end
      end
      if (sense_i[c] > q.ch[c].ov_lim) begin
        n.ovf[c] = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  function automatic vvl_st_s rst_state();
    vvl_st_s r;
    r = '0;
    r.vin_start = vvl_pkg::RST_VIN_START;
    r.vin_stop  = vvl_pkg::RST_VIN_STOP;
    r.vin_ov  = vvl_pkg::RST_VIN_OV;
    r.vin_uvw = vvl_pkg::RST_VIN_UVW;
    for (int c = 0; c < NCH; c++) begin
      r.ch[c].setpoint  = vvl_pkg::RST_SETPOINT;
      r.ch[c].ceil      = vvl_pkg::RST_CEIL;
      r.ch[c].mhigh     = vvl_pkg::RST_MHIGH;
      r.ch[c].mlow      = vvl_pkg::RST_MLOW;
      r.ch[c].ov_lim    = vvl_pkg::RST_OV_FAULT;
      r.ch[c].ov_warn   = vvl_pkg::RST_OV_WARN;
      r.ch[c].uv_warn   = vvl_pkg::RST_UV_WARN;
      r.ch[c].uv_lim    = vvl_pkg::RST_UV_FAULT;
      r.ch[c].load_line = vvl_pkg::RST_LOAD_LINE;
    end
    return r;
  endfunction

  localparam vvl_st_s ST_RST = rst_state();

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign conv_en_o       = q.conv_on;
  assign ov_fault_o      = q.ovf;
  assign vout_sum_o      = q.st_vout;
  assign vout_cap_warn_o = q.st_vmax;
  assign status_o        = q.st;
  assign common_vendor_status_o = (q.settle == 32'h0000_0000) ? vvl_pkg::CS_OV_MASK : 8'h00;
  assign alert_n_o = ~((q.st.input_uvw & ~mask_uvw_i) |
                       ((|q.st_vmax) & ~mask_vmax_i) |
                       q.st.vin_ov | q.st.cml | (|q.ovf));

endmodule

// ### test/vvl_limit_bank_props.sv
// Port assertions for the voltage limit bank.
// Assumes binding into the bank; link and core domains.
`timescale 1ns/1ps
module vvl_limit_bank_props #(
  parameter int NCH = 2
) (
  // Clocks and reset
  input wire logic               core_clk_i,
  input wire logic               link_clk_i,
  input wire logic               rst_n_i,
  // Watched ports
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire vvl_pkg::vvl_rsp_s  rsp_o,
  input wire logic [NCH-1:0]     servo_req_i,
  input wire logic               status_clr_i,
  input wire logic               mask_uvw_i,
  input wire logic               mask_vmax_i,
  input wire logic [NCH-1:0]     ov_fault_o,
  input wire logic [NCH-1:0]     vout_cap_warn_o,
  input wire logic [NCH-1:0]     servo_en_o,
  input wire logic [NCH-1:0]     load_line_on_o,
  input wire vvl_pkg::vvl_stat_s status_o,
  input wire logic [7:0]         common_vendor_status_o,
  input wire logic               alert_n_o
);
  // ==========
  // Link port
  done_pulse_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    done_o |=> !done_o) else $error("done too long");
  busy_bound_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    busy_o |-> ##[0:12] !busy_o) else $error("busy hung");
  rsp_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $changed(rsp_o) |-> done_o) else $error("answer moved");
  // ==========
  // Status
  uvw_alert_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    status_o.input_uvw && !mask_uvw_i |-> !alert_n_o) else $error("no uvw alert");
  vmax_alert_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (|vout_cap_warn_o) && !mask_vmax_i |-> !alert_n_o) else $error("no ceiling alert");
  servo_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    servo_en_o == (servo_req_i & ~load_line_on_o)) else $error("servo gate");
  vin_ov_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    status_o.vin_ov && !status_clr_i |=> status_o.vin_ov) else $error("vin ov lost");
  ov_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !status_clr_i |=> (ov_fault_o & $past(ov_fault_o)) == $past(ov_fault_o))
    else $error("ov fault lost");
  settle_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    common_vendor_status_o != 8'h60 |-> common_vendor_status_o == 8'h00
    ##[1:1000] common_vendor_status_o == 8'h60) else $error("settle status");
endmodule

bind vvl_limit_bank vvl_limit_bank_props #(.NCH(NCH)) i_vvl_limit_bank_props (
  .core_clk_i, .link_clk_i, .rst_n_i, .busy_o, .done_o, .rsp_o, .servo_req_i,
  .status_clr_i, .mask_uvw_i, .mask_vmax_i, .ov_fault_o, .vout_cap_warn_o,
  .servo_en_o, .load_line_on_o, .status_o, .common_vendor_status_o, .alert_n_o);

// ### test/vvl_host_model.sv
// Host command model: one request at a time on the link clock.
// Assumes the bank answers with a one-cycle done pulse.
`timescale 1ns/1ps
module vvl_host_model (
  // Link clock
  input  wire logic              link_clk_i,
  // Bank answer
  input  wire logic              busy_i,
  input  wire logic              done_i,
  input  wire vvl_pkg::vvl_rsp_s rsp_i,
  // Request
  output logic                   req_valid_o,
  output vvl_pkg::vvl_req_s      req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // ==========
  // Transfer
  task automatic xfer(input logic w, input logic [7:0] pg, cm, input logic [15:0] d,
                      output vvl_pkg::vvl_rsp_s r);
    int n;
    @(posedge link_clk_i);
    req_valid_o <= 1'b1;
    req_o <= {w, pg, cm, d};
    @(posedge link_clk_i);
    while (busy_i !== 1'b0) @(posedge link_clk_i);
    req_valid_o <= 1'b0;
    // Released lines float, so show the inverse
    req_o <= ~req_o;
    for (n = 0; n < 20 && done_i !== 1'b1; n++) @(posedge link_clk_i);
    if (n < 20) r = rsp_i;
    else r = 'x;
  endtask
endmodule

// ### test/tb_vvl_limit_bank.sv
// Testbench for the voltage limit bank with the host model.
// Assumes two channels and shortened settle and slew counts.
`timescale 1ns/1ps
module tb_vvl_limit_bank;
  // ==========
  // Signals
  logic core_clk_i = 0, link_clk_i = 0, rst_n_i = 0, req_valid_i;
  logic busy_o, done_o, conv_en_o, alert_n_o, status_clr_i = 0;
  logic mask_uvw_i = 0, mask_vmax_i = 0;
  logic [7:0] common_vendor_status_o;
  logic [15:0] vin_adc_i = 16'hCA00;
  logic [1:0][15:0] sense_i = '0, vout_ref_o;
  logic [1:0][1:0] margin_i = '0;
  logic [1:0] enable_i = '0, ramp_busy_i = '0, range_i = '0, servo_req_i = '0;
  logic [1:0] ov_fault_o, vout_sum_o, vout_cap_warn_o, servo_en_o, load_line_on_o;
  vvl_pkg::vvl_req_s req_i;
  vvl_pkg::vvl_rsp_s rsp_o;
  vvl_pkg::vvl_stat_s status_o;
  int failures = 0, tests_run = 0, cyc = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  always #24 link_clk_i = ~link_clk_i;
  vvl_limit_bank #(.NCH(2), .OV_SETTLE_CYC(400), .SLEW_CYC(2)) i_vvl_limit_bank (
    .core_clk_i, .link_clk_i, .rst_n_i, .req_valid_i, .req_i, .busy_o, .done_o,
    .rsp_o, .vin_adc_i, .sense_i, .enable_i, .ramp_busy_i, .margin_i, .range_i,
    .servo_req_i, .status_clr_i, .mask_uvw_i, .mask_vmax_i, .vout_ref_o, .conv_en_o,
    .ov_fault_o, .vout_sum_o, .vout_cap_warn_o, .servo_en_o, .load_line_on_o,
    .status_o, .common_vendor_status_o, .alert_n_o);
  vvl_host_model i_vvl_host_model (.link_clk_i, .busy_i(busy_o), .done_i(done_o),
    .rsp_i(rsp_o), .req_valid_o(req_valid_i), .req_o(req_i));
  // ==========
  // Helpers
  task automatic results;
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write checks the fault flag, read checks the data
  task automatic xf(input logic w, input logic [7:0] pg, cm, input logic [15:0] d, e);
    vvl_pkg::vvl_rsp_s r;
    i_vvl_host_model.xfer(w, pg, cm, d, r);
    if (w) chk(16'(r.cml), e);
    else chk(r.rdata, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wait_ref(input logic [15:0] e);
    int n;
    for (n = 0; n < 20000 && vout_ref_o[0] !== e; n++) tick(1);
    chk(vout_ref_o[0], e);
  endtask
  // ==========
  // Scenarios
  task automatic t_defaults;
    logic [23:0] t [15] = '{24'h200014, 24'h211000, 24'h245800, 24'h2510CD, 24'h260F33,
      24'h35CB40, 24'h36CB00, 24'h40119A, 24'h421133, 24'h430ECD, 24'h440E66,
      24'h55D3E0, 24'h58CB26, 24'hA5599A, 24'hD38000};
    foreach (t[i]) xf(1'b0, 8'h01, t[i][23:16], 16'h0000, t[i][15:0]);
  endtask
  task automatic t_readonly;
    xf(1'b1, 8'h00, 8'h20, 16'h0055, 16'h0001);
    xf(1'b0, 8'h00, 8'h20, 16'h0000, 16'h0014);
    xf(1'b1, 8'h00, 8'hA5, 16'h0000, 16'h0001);
    xf(1'b0, 8'h00, 8'hA5, 16'h0000, 16'h599A);
    chk(16'(status_o.cml), 16'h0001);
  endtask
  task automatic t_paging;
    xf(1'b1, 8'h01, 8'h21, 16'h1010, 16'h0000);
    xf(1'b0, 8'h00, 8'h21, 16'h0000, 16'h1000);
    xf(1'b0, 8'h01, 8'h21, 16'h0000, 16'h1010);
    xf(1'b1, 8'h00, 8'h35, 16'hCB50, 16'h0000);
    xf(1'b0, 8'h01, 8'h35, 16'h0000, 16'hCB50);
    xf(1'b1, 8'h05, 8'h21, 16'h1000, 16'h0001);
    xf(1'b1, 8'hFF, 8'h43, 16'h0E00, 16'h0000);
    xf(1'b0, 8'h01, 8'h43, 16'h0000, 16'h0E00);
  endtask
  task automatic t_ramp;
    wait_ref(16'h1000);
    ramp_busy_i <= 2'b01;
    xf(1'b1, 8'h00, 8'h21, 16'h1010, 16'h0000);
    tick(30);
    chk(vout_ref_o[0], 16'h1000);
    ramp_busy_i <= 2'b00;
    wait_ref(16'h1010);
    margin_i[0] <= vvl_pkg::MARG_HIGH;
    wait_ref(16'h10CD);
    margin_i[0] <= vvl_pkg::MARG_LOW;
    wait_ref(16'h0F33);
    margin_i[0] <= vvl_pkg::MARG_NOM;
  endtask
  task automatic t_ceiling;
    xf(1'b1, 8'h00, 8'h24, 16'hFFFF, 16'h0001);
    xf(1'b0, 8'h00, 8'h24, 16'h0000, 16'h599A);
    tick(3);
    chk(16'(vout_cap_warn_o[0]), 16'h0001);
    xf(1'b1, 8'h00, 8'h24, 16'h1008, 16'h0000);
    xf(1'b0, 8'h00, 8'h21, 16'h0000, 16'h1008);
    wait_ref(16'h1008);
    chk(16'({vout_sum_o[0], alert_n_o}), 16'h0002);
    // Range 1 makes the channel 1 default ceiling too high
    range_i <= 2'b10;
    tick(3);
    chk(16'(vout_cap_warn_o), 16'h0003);
    range_i <= 2'b00;
  endtask
  task automatic t_vin;
    tick(1);
    status_clr_i <= 1'b1;
    vin_adc_i <= 16'hD1C0;
    tick(1);
    status_clr_i <= 1'b0;
    tick(4);
    chk(16'(conv_en_o), 16'h0001);
    vin_adc_i <= 16'hCA00;
    tick(4);
    chk(16'({conv_en_o, status_o.input_uvw}), 16'h0000);
    vin_adc_i <= 16'hD1C0;
    enable_i <= 2'b01;
    tick(4);
    vin_adc_i <= 16'hCA00;
    tick(4);
    chk(16'({status_o.input_sum, status_o.input_uvw, alert_n_o}), 16'h0006);
    vin_adc_i <= 16'hD1C0;
    mask_uvw_i <= 1'b1;
    status_clr_i <= 1'b1;
    tick(1);
    status_clr_i <= 1'b0;
    vin_adc_i <= 16'hCA00;
    tick(4);
    chk(16'({status_o.input_uvw, alert_n_o}), 16'h0003);
    vin_adc_i <= 16'hD3F0;
    tick(4);
    chk(16'(status_o.vin_ov), 16'h0001);
  endtask
  task automatic t_ov;
    int n;
    sense_i[0] <= 16'h119B;
    tick(4);
    chk(16'(ov_fault_o), 16'h0001);
    xf(1'b1, 8'h00, 8'h40, 16'h1200, 16'h0000);
    chk(16'(common_vendor_status_o), 16'h0000);
    // Hold off the load-line write until the new limit is in force
    for (n = 0; n < 1000 && common_vendor_status_o !== 8'h60; n++) tick(1);
    chk(16'(common_vendor_status_o), 16'h0060);
    xf(1'b1, 8'h00, 8'hD3, 16'h8001, 16'h0000);
    tick(1);
    servo_req_i <= 2'b11;
    tick(3);
    chk(16'({load_line_on_o, servo_en_o}), 16'h0006);
  endtask
  // ==========
  // Sequence
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end
  initial begin
    tick(8);
    repeat (2) @(posedge link_clk_i);
    tick(1);
    rst_n_i <= 1'b1;
    t_defaults();
    t_readonly();
    t_paging();
    t_ramp();
    t_ceiling();
    t_vin();
    t_ov();
    results();
  end
endmodule
